// >>> shared/brw_pkg.sv
// Shared constants and types for the byte-wide RAM with real-time clock window.
`default_nettype none
package brw_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int RAM_WORDS = 8184;
    localparam int TIME_REGS = 7;
    localparam logic [12:0] ADDR_CONTROL = 13'h1FF8;
    localparam logic [12:0] ADDR_SECONDS = 13'h1FF9;
    localparam logic [12:0] ADDR_MINUTES = 13'h1FFA;
    localparam logic [12:0] ADDR_HOURS = 13'h1FFB;
    localparam logic [12:0] ADDR_WEEKDAY = 13'h1FFC;
    localparam logic [12:0] ADDR_DAY_OF_MONTH = 13'h1FFD;
    localparam logic [12:0] ADDR_MONTH = 13'h1FFE;
    localparam logic [12:0] ADDR_YEAR = 13'h1FFF;
    // Index of each time register, counted from the seconds register.
    localparam int IDX_SEC = 0;
    localparam int IDX_MIN = 1;
    localparam int IDX_HOUR = 2;
    localparam int IDX_DAY = 3;
    localparam int IDX_DATE = 4;
    localparam int IDX_MONTH = 5;
    localparam int IDX_YEAR = 6;
    localparam int CTRL_WRITE_HOLD_BIT = 7;
    localparam int CTRL_READ_HOLD_BIT = 6;
    localparam int CTRL_SIGN_BIT = 5;
    localparam int CAL_W = 5;
    localparam int OSC_STOP_BIT = 7;
    localparam int FREQ_TEST_BIT = 6;
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_ZERO_FIELD = 8'h00;
    localparam logic [7:0] RST_ONE_FIELD = 8'h01;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLK_HZ_NOMINAL = 1000000000 / CLK_PERIOD_NS;
    localparam int OSC_HZ = 32768;
    localparam int FT_HZ = 512;
    localparam logic [15:0] OSC_PER_SEC = 16'(OSC_HZ);
    localparam logic [15:0] CAL_SHORTEN = 16'h0080;
    localparam logic [15:0] CAL_LENGTHEN = 16'h0100;
    localparam logic [6:0] CAL_ACTIVE_MINUTES = 7'h3E;
    localparam logic [4:0] FT_HALF_TICKS = 5'(OSC_HZ / (2 * FT_HZ) - 1);

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } brw_bus_t;
endpackage : brw_pkg
`default_nettype wire

// >>> logic/brw_rtc.sv
// Byte-wide static RAM with a BCD real-time clock in its top eight bytes.
//
// Behaviour
// RL1 - Read hold freezes the visible time bytes while the counters keep running.
// RL2 - On hold, visible bytes show the time current at the hold instant.
// RL3 - All visible bytes refresh together in one cycle; refresh is never split.
// RL4 - Clearing read hold resumes refreshing within one second.
// RL5 - Write hold stops refreshing so the host can load new time values.
// RL6 - Clearing write hold copies all visible time bytes into the counters.
// RL7 - Counters keep 24-hour packed BCD with the documented ranges.
// RL8 - Host writes zero to frequency test and must-be-zero bits normally.
// RL9 - Writing the seconds MSB to one stops the oscillator.
// RL10 - Clearing the stop bit restarts the oscillator within one second.
// RL11 - Host should toggle the stop bit one then zero after power-up.
// RL12 - Calibration adds or removes pulses at the divide-by-256 stage.
// RL13 - Calibration magnitude is the five low control bits, 0 to 31.
// RL14 - Control bit 5 set speeds the clock, clear slows it.
// RL15 - 64-minute cycle; one second per minute corrected in first 62 minutes.
// RL16 - Magnitude N corrects only the first 2N minutes of the cycle.
// RL17 - Frequency test bit makes seconds bit 0 toggle at 512 Hz.
// RL18 - Frequency test rate ignores the calibration setting.
// RL19 - Host holds an extended read of seconds to watch the test output.
// RL20 - Host writes only with strobe and select low and select high.
// RL21 - Addresses below the clock block are plain read/write memory.
`timescale 1ns/1ps
`default_nettype none
module brw_rtc
    import brw_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_NOMINAL
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and helpers.

    logic rst_meta;
    logic rst_sync;
    // Every other flop except the memory array resets from this synchronised copy so that release is clean.

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Returns {carry, next} for a BCD field that wraps from last to first.
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
        logic [8:0] r;
        r = {1'b0, v};
        if (v == last) begin
            r = {1'b1, first};
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_step

    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        logic [7:0] r;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[1:0] == 2'b00 && !yr[0]);
        unique case (mon)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction : month_last

    ////////////////////////////////////////////////////////////////////////////
    // Bus sampling; a write commits when its strobe window closes.

    brw_bus_t bus_now;
    brw_bus_t bus_prev;
    logic selected;
    logic write_done;
    logic in_clock_block;

    assign selected = !chip_select_low_n && chip_select_high;
    assign bus_now = '{addr: addr, data: data_in, wr: selected && !write_strobe_n,
                       rd: selected && write_strobe_n && !output_enable_n};
    // The commit uses the address and data of the last strobe cycle, sampled one edge back.
    assign write_done = bus_prev.wr && !bus_now.wr; // RL20
    assign in_clock_block = bus_prev.addr >= ADDR_CONTROL;

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            bus_prev <= '0;
        end else begin
            bus_prev <= bus_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Plain memory below the clock block.

    logic [DATA_W-1:0] ram [RAM_WORDS];

    always_ff @(posedge mclk) begin
        if (write_done && !in_clock_block) begin
            ram[bus_prev.addr] <= bus_prev.data; // RL21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator tick from the system clock, stop control and test toggle.

    logic [31:0] phase;
    logic [31:0] next_phase;
    logic osc_tick;
    logic osc_stop;
    logic freq_test;
    logic [4:0] ft_count;
    logic ft_level;

    // The phase accumulator turns the system clock into the crystal tick; a stop freezes it.
    assign next_phase = phase + 32'(OSC_HZ);
    assign osc_tick = !osc_stop && (next_phase >= 32'(CLK_HZ)); // RL9 RL10

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            phase <= '0;
            ft_count <= '0;
            ft_level <= 1'b0;
        end else begin
            if (osc_tick) begin
                phase <= next_phase - 32'(CLK_HZ);
                ft_count <= (ft_count == FT_HALF_TICKS) ? 5'h00 : ft_count + 5'h01; // RL18
                ft_level <= (ft_count == FT_HALF_TICKS) ? !ft_level : ft_level; // RL17
            end else if (!osc_stop) begin
                phase <= next_phase;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control byte and visible time bytes.

    logic [7:0] control;
    logic [7:0] vis [TIME_REGS];
    logic [7:0] cnt [TIME_REGS];
    logic hold;
    logic write_release;
    logic [2:0] wr_idx;
    logic time_write;

    assign hold = control[CTRL_READ_HOLD_BIT] || control[CTRL_WRITE_HOLD_BIT]; // RL1 RL5
    assign wr_idx = 3'(bus_prev.addr - ADDR_SECONDS);
    assign time_write = write_done && bus_prev.addr >= ADDR_SECONDS;
    assign write_release = write_done && bus_prev.addr == ADDR_CONTROL && control[CTRL_WRITE_HOLD_BIT]
                           && !bus_prev.data[CTRL_WRITE_HOLD_BIT];

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            control <= RST_CONTROL;
            osc_stop <= 1'b0;
            freq_test <= 1'b0;
        end else if (write_done) begin
            if (bus_prev.addr == ADDR_CONTROL) begin
                control <= bus_prev.data; // RL13 RL14
            end
            if (bus_prev.addr == ADDR_SECONDS) begin
                osc_stop <= bus_prev.data[OSC_STOP_BIT]; // RL9 RL10
            end
            if (bus_prev.addr == ADDR_WEEKDAY) begin
                freq_test <= bus_prev.data[FREQ_TEST_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            for (int i = 0; i < TIME_REGS; i++) begin
                vis[i] <= (i == IDX_DAY || i == IDX_DATE || i == IDX_MONTH) ? RST_ONE_FIELD : RST_ZERO_FIELD;
            end
        end else if (hold) begin
            // Host writes land in the visible bytes and reach the counters on write-hold release.
            if (time_write) begin
                vis[wr_idx] <= bus_prev.data; // RL5
            end
        end else begin
            for (int i = 0; i < TIME_REGS; i++) begin
                vis[i] <= cnt[i]; // RL2 RL3 RL4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler with periodic correction and the BCD counter chain.

    logic [15:0] presc;
    logic [15:0] sec_len;
    logic [5:0] cal_min;
    logic cal_now;
    logic sec_pulse;
    logic [8:0] s_sec;
    logic [8:0] s_min;
    logic [8:0] s_hour;
    logic [8:0] s_day;
    logic [8:0] s_date;
    logic [8:0] s_month;
    logic [8:0] s_year;

    // The correction minute count runs free from reset; reloading the time does not restart it.
    assign cal_now = cnt[IDX_SEC] == 8'h00 && {1'b0, cal_min} < {1'b0, control[CAL_W-1:0], 1'b0}
                     && {1'b0, cal_min} < CAL_ACTIVE_MINUTES; // RL15 RL16
    assign sec_len = !cal_now ? OSC_PER_SEC
                   : control[CTRL_SIGN_BIT] ? OSC_PER_SEC - CAL_SHORTEN : OSC_PER_SEC + CAL_LENGTHEN; // RL12 RL14
    assign sec_pulse = osc_tick && presc == sec_len - 16'h0001;

    assign s_sec = bcd_step(cnt[IDX_SEC], 8'h59, 8'h00); // RL7
    assign s_min = bcd_step(cnt[IDX_MIN], 8'h59, 8'h00);
    assign s_hour = bcd_step(cnt[IDX_HOUR], 8'h23, 8'h00);
    assign s_day = bcd_step(cnt[IDX_DAY], 8'h07, 8'h01);
    assign s_date = bcd_step(cnt[IDX_DATE], month_last(cnt[IDX_MONTH], cnt[IDX_YEAR]), 8'h01);
    assign s_month = bcd_step(cnt[IDX_MONTH], 8'h12, 8'h01);
    assign s_year = bcd_step(cnt[IDX_YEAR], 8'h99, 8'h00);

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            presc <= '0;
            cal_min <= '0;
            for (int i = 0; i < TIME_REGS; i++) begin
                cnt[i] <= (i == IDX_DAY || i == IDX_DATE || i == IDX_MONTH) ? RST_ONE_FIELD : RST_ZERO_FIELD;
            end
        end else if (write_release) begin
            presc <= '0;
            cnt[IDX_SEC] <= vis[IDX_SEC] & MASK_SEC; // RL6
            cnt[IDX_MIN] <= vis[IDX_MIN] & MASK_MIN;
            cnt[IDX_HOUR] <= vis[IDX_HOUR] & MASK_HOUR;
            cnt[IDX_DAY] <= vis[IDX_DAY] & MASK_DAY;
            cnt[IDX_DATE] <= vis[IDX_DATE] & MASK_DATE;
            cnt[IDX_MONTH] <= vis[IDX_MONTH] & MASK_MONTH;
            cnt[IDX_YEAR] <= vis[IDX_YEAR] & MASK_YEAR;
        end else if (sec_pulse) begin
            presc <= '0;
            cnt[IDX_SEC] <= s_sec[7:0]; // RL7
            if (s_sec[8]) begin
                cnt[IDX_MIN] <= s_min[7:0];
                cal_min <= cal_min + 6'h01; // RL15
                if (s_min[8]) begin
                    cnt[IDX_HOUR] <= s_hour[7:0];
                    if (s_hour[8]) begin
                        cnt[IDX_DAY] <= s_day[7:0];
                        cnt[IDX_DATE] <= s_date[7:0];
                        if (s_date[8]) begin
                            cnt[IDX_MONTH] <= s_month[7:0];
                            if (s_month[8]) begin
                                cnt[IDX_YEAR] <= s_year[7:0];
                            end
                        end
                    end
                end
            end
        end else if (osc_tick) begin
            presc <= presc + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; data and enable are registered.

    logic [7:0] rd_sel;
    logic [2:0] rd_idx;
    logic [7:0] rd_time;

    // Seconds bit 7 and weekday bit 6 read the live stop and test flags, not the stored bits.
    assign rd_idx = 3'(addr - ADDR_SECONDS);
    assign rd_time = (addr == ADDR_SECONDS) ? {osc_stop, vis[IDX_SEC][6:1], freq_test ? ft_level : vis[IDX_SEC][0]}
                   : (addr == ADDR_WEEKDAY) ? {1'b0, freq_test, vis[IDX_DAY][5:0]}
                   : vis[rd_idx]; // RL17
    assign rd_sel = (addr < ADDR_CONTROL) ? ram[addr] : (addr == ADDR_CONTROL) ? control : rd_time; // RL21

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            data_out <= '0;
            data_oe <= 1'b0;
        end else begin
            data_out <= rd_sel;
            data_oe <= bus_now.rd;
        end
    end

endmodule : brw_rtc
`default_nettype wire

// >>> tb/brw_rtc_props.sv
// Port-level assertions for the byte-wide RAM with real-time clock window.
`timescale 1ns/1ps
`default_nettype none
module brw_rtc_props
    import brw_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_NOMINAL
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high
);
    // The design's internal reset copy lags the pin, so checks other than a_strobe_quiets wait four edges.
    logic [2:0] up_cnt;
    wire live = up_cnt == 3'h4;
    wire sel = !chip_select_low_n && chip_select_high;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            up_cnt <= 3'h0;
        end else if (!live) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////
    a_read_drives_bus: assert property (live && sel && !output_enable_n && write_strobe_n |=> data_oe)
        else $error("read cycle left the data bus undriven");
    a_deselect_quiets: assert property (live && !sel |=> !data_oe)
        else $error("data bus driven while deselected");
    a_strobe_quiets: assert property (!write_strobe_n |=> !data_oe)
        else $error("data bus driven during a write");
    a_ram_stable: assert property ((live && write_strobe_n) [*3] ##0 (addr < ADDR_CONTROL && $stable(addr))
        |=> $stable(data_out)) else $error("memory byte changed without a write");
    a_stop_freezes: assert property (live && data_out[OSC_STOP_BIT] && addr == ADDR_SECONDS
        && $past(addr) == ADDR_SECONDS && write_strobe_n && $past(write_strobe_n)
        && $past(write_strobe_n, 2) && $past(write_strobe_n, 3)
        |=> $stable(data_out)) else $error("seconds moved while stopped");
    a_hours_range: assert property (live && $past(addr) == ADDR_HOURS
        |-> data_out[5:0] <= 6'h23 && data_out[3:0] <= 4'h9) else $error("hours out of range");
    a_minutes_range: assert property (live && $past(addr) == ADDR_MINUTES
        |-> data_out[6:4] <= 3'h5 && data_out[3:0] <= 4'h9) else $error("minutes out of range");
    a_weekday_range: assert property (live && $past(addr) == ADDR_WEEKDAY |-> data_out[2:0] != 3'h0)
        else $error("weekday out of range");
    c_read: cover property (live && data_oe);
    c_stopped: cover property (live && $past(addr) == ADDR_SECONDS && data_out[OSC_STOP_BIT]);
    c_ctrl_write: cover property ($rose(write_strobe_n) && addr == ADDR_CONTROL);
endmodule : brw_rtc_props
bind brw_rtc brw_rtc_props #(.CLK_HZ(CLK_HZ)) u_props (.mclk(mclk), .rstn(rstn), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .chip_select_low_n(chip_select_low_n),
    .chip_select_high(chip_select_high));
`default_nettype wire

// >>> tb/brw_host.sv
// Host model that runs byte-wide RAM cycles on the device pins.
`timescale 1ns/1ps
`default_nettype none
module brw_host
    import brw_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] data_out,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data_in,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic chip_select_low_n,
    output logic chip_select_high
);
    initial begin
        addr = '0;
        data_in = 8'h00;
        write_strobe_n = 1'b1;
        output_enable_n = 1'b1;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        data_in <= d;
        output_enable_n <= 1'b1;
        chip_select_low_n <= 1'b0;
        chip_select_high <= 1'b1;
        write_strobe_n <= 1'b0;
        @(posedge mclk);
        write_strobe_n <= 1'b1;
        @(posedge mclk);
        chip_select_low_n <= 1'b1;
        chip_select_high <= 1'b0;
        data_in <= ~d;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        output_enable_n <= 1'b0;
        chip_select_low_n <= 1'b0;
        chip_select_high <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 d = data_out;
    endtask : rd
endmodule : brw_host
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the byte-wide RAM with real-time clock window.
`timescale 1ns/1ps
`default_nettype none
`define BRW_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module testbench
    import brw_pkg::*;
;
    localparam int SIM_HZ = 32768;
    localparam int FLIP_CYC = SIM_HZ / (2 * FT_HZ);
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic write_strobe_n;
    logic output_enable_n;
    logic chip_select_low_n;
    logic chip_select_high;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    brw_rtc #(.CLK_HZ(SIM_HZ)) dut (.mclk(mclk), .rstn(rstn), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high));
    brw_host host (.mclk(mclk), .data_out(data_out), .addr(addr), .data_in(data_in),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
        .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high));
    always #10 mclk = ~mclk;
    task automatic test_done();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            test_done();
        end
    end
    ////////////////////////////////////////////////
    task automatic t_ram();
        logic [7:0] v;
        host.wr(13'h0010, 8'hA5);
        host.wr(ADDR_CONTROL - 13'h1, 8'h3C);
        host.rd(13'h0010, v);
        `BRW_CHK(v, 8'hA5)
        `BRW_CHK(data_oe, 1'b1)
        host.rd(ADDR_CONTROL - 13'h1, v);
        `BRW_CHK(v, 8'h3C)
    endtask : t_ram
    task automatic t_reset_vals();
        logic [7:0] v;
        logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        for (int i = 0; i < 8; i++) begin
            host.rd(ADDR_CONTROL + 13'(i), v);
            `BRW_CHK(v, exp[i])
        end
    endtask : t_reset_vals
    // Loads the last second of a year, holds across the rollover, then releases.
    task automatic t_rollover();
        logic [7:0] v;
        logic [7:0] load [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
        logic [7:0] roll [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        host.wr(ADDR_CONTROL, 8'h80);
        for (int i = 0; i < 7; i++) begin
            host.wr(ADDR_SECONDS + 13'(i), load[i]);
        end
        host.rd(ADDR_HOURS, v);
        `BRW_CHK(v, 8'h23)
        host.wr(ADDR_CONTROL, 8'h00);
        repeat (SIM_HZ - 200) @(posedge mclk);
        // Read hold with a positive correction of one, so minutes 0 and 1 of the cycle are trimmed.
        host.wr(ADDR_CONTROL, 8'h61);
        repeat (400) @(posedge mclk);
        host.rd(ADDR_SECONDS, v);
        `BRW_CHK(v, 8'h59)
        host.wr(ADDR_CONTROL, 8'h21);
        for (int i = 0; i < 7; i++) begin
            host.rd(ADDR_SECONDS + 13'(i), v);
            `BRW_CHK(v, roll[i])
        end
        // The rollover entered minute 1, whose second 00 is shortened by 128 ticks.
        repeat (SIM_HZ - int'(CAL_SHORTEN) - 300) @(posedge mclk);
        host.rd(ADDR_SECONDS, v);
        `BRW_CHK(v, 8'h00)
        repeat (120) @(posedge mclk);
        host.rd(ADDR_SECONDS, v);
        `BRW_CHK(v, 8'h01)
    endtask : t_rollover
    task automatic count_flips(output int n);
        logic [7:0] v;
        logic last;
        host.rd(ADDR_SECONDS, v);
        last = v[0];
        n = 0;
        repeat (20 * FLIP_CYC) begin
            @(posedge mclk);
            #1;
            if (data_out[0] !== last) begin
                n++;
            end
            last = data_out[0];
        end
    endtask : count_flips
    task automatic t_freq_test();
        int n;
        host.wr(ADDR_SECONDS, 8'h80);
        host.wr(ADDR_WEEKDAY, 8'h41);
        count_flips(n);
        `BRW_CHK(n, 0)
        host.wr(ADDR_SECONDS, 8'h00);
        count_flips(n);
        `BRW_CHK(n, 20)
        host.wr(ADDR_CONTROL, 8'h3F);
        count_flips(n);
        `BRW_CHK(n, 20)
        host.wr(ADDR_CONTROL, 8'h1F);
        count_flips(n);
        `BRW_CHK(n, 20)
        host.wr(ADDR_CONTROL, 8'h00);
        host.wr(ADDR_WEEKDAY, 8'h01);
    endtask : t_freq_test
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset_vals();
        t_ram();
        t_rollover();
        t_freq_test();
        test_done();
    end
endmodule : testbench
`default_nettype wire
